/* File: src/emdma_cfg.svh */
// constants for the external memory interface and byte transfer engine
// assumes inclusion by bare name from the design files
`ifndef EMDMA_CFG_SVH
`define EMDMA_CFG_SVH

`define EMDMA_DM_INT_BASE      14'h2000
`define EMDMA_DM_INT_WORDS     8160
`define EMDMA_DOVL_INTERNAL    2'h0
`define EMDMA_DOVL_SECOND      2'h2
`define EMDMA_IO_ADDR_MSB      10
`define EMDMA_IO_REGION_LSB    9
`define EMDMA_WAIT_W           3
`define EMDMA_IO_REGIONS       4

`define EMDMA_SEL_PMS          0
`define EMDMA_SEL_DMS          1
`define EMDMA_SEL_BMS          2
`define EMDMA_SEL_IO_SPACE_SELECT         3
`define EMDMA_CMS_EN_RESET     4'hB
`define EMDMA_BMS_DIS_BIT      3

`define EMDMA_WORD_W           24
`define EMDMA_FIFO_DEPTH       8
`define EMDMA_COUNT_W          14
`define EMDMA_PAGE_W           8
`define EMDMA_BYTES_PM24       2'h3
`define EMDMA_BYTES_DM16       2'h2
`define EMDMA_BYTES_DM8        2'h1

`endif

/* File: src/emdma_fifo.sv */
// word fifo between on-chip memory side and byte side of the transfer engine
// assumes one clock, asynchronous active-low reset
`timescale 1ns/100ps
module emdma_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
         end
         if (push && !pop) begin
            count_reg <= (PW+1)'(count_reg + 1'b1);
         end else if (pop && !push) begin
            count_reg <= (PW+1)'(count_reg - 1'b1);
         end
      end
   end
endmodule

/* File: src/emdma_pkg.sv */
// types shared by the external memory interface design files
// assumes nothing of its surroundings
package emdma_pkg;

   typedef enum logic [1:0] {
      EMDMA_XS_IDLE    = 2'h0,
      EMDMA_XS_STROBE  = 2'h1,
      EMDMA_XS_RELEASE = 2'h3
   } emdma_xstate_t;

   typedef enum logic [1:0] {
      EMDMA_FMT_PM24  = 2'h0,
      EMDMA_FMT_DM16  = 2'h1,
      EMDMA_FMT_DM8HI = 2'h2,
      EMDMA_FMT_DM8LO = 2'h3
   } emdma_fmt_t;

endpackage

/* File: src/emdma_top.sv */
// external memory interface: data overlays, wait states, selects, byte transfer engine
// assumes synchronous inputs, single-cycle on-chip memory with data the cycle after grant
//
// Behaviour
// - overlay select zero: data accesses are served on chip, one cycle.
// - overlay nonzero: data addresses 0x0000-0x1FFF go to external memory.
// - overlay 1 drives A13 low, overlay 2 high; A12:0 from core address.
// - internal data accesses finish in one cycle, never stretched.
// - external data accesses stretched by the data wait count.
// - io accesses use eleven low address bits; upper three are don't-care.
// - io wait count picked per 512-word region from four 3-bit settings.
// - combined select follows any enabled individual select, same timing; byte accesses drive it from the boot enable even with boot select suppressed.
// - reset sets all combined-select enables except the boot select one.
// - boot select suppressed while system control bit 3 is set.
// - byte data on lines 15:8; page on 23:16 plus address 13:0.
// - 256 pages of 16K bytes; sequential addressing carries into next page.
// - every byte access timed by the byte space wait count.
// - engine runs beside core, one on-chip cycle per assembled word.
// - format: 00 program 24-bit, 01 data 16, 10 upper byte, 11 lower.
// - unused half of an 8-bit data word is filled with zeros.
// - start from on-chip address, byte address, page, and direction bit.
// - nonzero word count write starts; count decrements per word, readable.
// - count reaching zero stops byte accesses and raises completion interrupt.
// - on-chip side always on-chip memory regardless of overlay settings.
// - core external accesses win over engine byte accesses.
// - hold-off bit holds core, clears context, restarts at 0 when done.
`timescale 1ns/100ps
`include "emdma_cfg.svh"
module emdma_top #(
   parameter int FIFO_DEPTH = `EMDMA_FIFO_DEPTH
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic [1:0]  data_overlay_select,
   input  wire logic [2:0]  data_wait_count,
   input  wire logic [11:0] io_region_wait_counts,
   input  wire logic [2:0]  byte_space_wait_count,
   input  wire logic [15:0] sys_ctrl,
   input  wire logic        cms_en_write,
   input  wire logic [3:0]  cms_en_wdata,
   input  wire logic        core_req,
   input  wire logic        core_io,
   input  wire logic        core_we,
   input  wire logic [13:0] core_addr,
   input  wire logic [15:0] core_wdata,
   input  wire logic [23:0] ext_data_in,
   input  wire logic [1:0]  transfer_format,
   input  wire logic [13:0] onchip_start_address,
   input  wire logic [13:0] byte_start_address,
   input  wire logic [7:0]  byte_start_page,
   input  wire logic        transfer_direction,
   input  wire logic        hold_off_and_restart,
   input  wire logic        word_count_write,
   input  wire logic [13:0] word_count_wdata,
   input  wire logic        mem_grant,
   input  wire logic [23:0] mem_rdata,
   output logic             core_ack,
   output logic [15:0]      core_rdata,
   output logic             dm_int_sel,
   output logic [13:0]      dm_int_addr,
   output logic [13:0]      ext_addr,
   output logic [23:0]      ext_data_out,
   output logic [2:0]       ext_data_oe_n,
   output logic             ext_rd_n,
   output logic             ext_wr_n,
   output logic             program_space_select_n,
   output logic             data_space_select_n,
   output logic             io_space_select_n,
   output logic             boot_select_n,
   output logic             combined_select_n,
   output logic [3:0]       combined_select_enables,
   output logic [13:0]      word_count,
   output logic             dma_busy,
   output logic             dma_done_irq,
   output logic             core_hold,
   output logic             core_restart,
   output logic             mem_req,
   output logic             mem_we,
   output logic             mem_pm,
   output logic [13:0]      mem_addr,
   output logic [23:0]      mem_wdata
);
   emdma_pkg::emdma_xstate_t xs_reg;
   emdma_pkg::emdma_fmt_t    fmt_reg;

   logic [2:0]  wait_reg;
   logic        owner_dma_reg;
   logic [23:0] cap_reg;
   logic        cpend_reg;
   logic        cio_reg;
   logic        cwe_reg;
   logic [13:0] caddr_reg;
   logic [15:0] cwdata_reg;
   logic        dir_reg;
   logic        hold_reg;
   logic [21:0] bptr_reg;
   logic [13:0] mptr_reg;
   logic [13:0] mem_left_reg;
   logic [1:0]  idx_reg;
   logic [15:0] asm_reg;
   logic [23:0] sh_reg;
   logic        rd_pend_reg;

   logic        core_is_int;
   logic        start_core;
   logic        start_dma;
   logic        dma_byte_req;
   logic        byte_done;
   logic        strobe_end;
   logic        last_byte;
   logic [1:0]  nbytes;
   logic [2:0]  core_wait;
   logic [13:0] core_ext_addr;
   logic [23:0] aligned;
   logic [7:0]  byte_out;
   logic [7:0]  rd_byte;
   logic [23:0] load_word;
   logic        dma_start;
   logic        dma_finish;
   logic        load_pop;
   logic        store_pop;
   logic        st_issue;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [23:0] fifo_in_data;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [23:0] fifo_out_data;
   logic [2:0]  io_wait_tab [0:`EMDMA_IO_REGIONS-1];

   // io wait table, one 3-bit setting per 512-word region
   genvar gi;
   generate
      for (gi = 0; gi < `EMDMA_IO_REGIONS; gi++) begin : g_iowait
         assign io_wait_tab[gi] = io_region_wait_counts[gi*3 +: 3];
      end
   endgenerate

   // core side decode
   assign core_is_int = core_req && !core_io &&
                        ((data_overlay_select == `EMDMA_DOVL_INTERNAL) ||
                         (core_addr >= `EMDMA_DM_INT_BASE));
   assign core_wait   = cio_reg ? io_wait_tab[caddr_reg[10:9]]
                                : data_wait_count;
   always_comb begin
      core_ext_addr = 14'h0000;
      if (cio_reg) begin
         core_ext_addr[`EMDMA_IO_ADDR_MSB:0] = caddr_reg[`EMDMA_IO_ADDR_MSB:0];
      end else begin
         core_ext_addr = {(data_overlay_select == `EMDMA_DOVL_SECOND), caddr_reg[12:0]};
      end
   end

   assign start_core = (xs_reg == emdma_pkg::EMDMA_XS_IDLE) && cpend_reg;
   assign start_dma  = (xs_reg == emdma_pkg::EMDMA_XS_IDLE) && !cpend_reg && dma_byte_req;
   assign strobe_end = (xs_reg == emdma_pkg::EMDMA_XS_STROBE) && (wait_reg == 3'h0);
   assign byte_done  = (xs_reg == emdma_pkg::EMDMA_XS_RELEASE) && owner_dma_reg;

   // byte side of the engine
   always_comb begin
      unique case (fmt_reg)
         emdma_pkg::EMDMA_FMT_PM24:  nbytes = `EMDMA_BYTES_PM24;
         emdma_pkg::EMDMA_FMT_DM16:  nbytes = `EMDMA_BYTES_DM16;
         emdma_pkg::EMDMA_FMT_DM8HI: nbytes = `EMDMA_BYTES_DM8;
         emdma_pkg::EMDMA_FMT_DM8LO: nbytes = `EMDMA_BYTES_DM8;
      endcase
   end
   assign last_byte = (idx_reg == 2'(nbytes - 2'h1));
   assign rd_byte   = cap_reg[15:8];

   // most significant byte goes out first in every format
   always_comb begin
      unique case (fmt_reg)
         emdma_pkg::EMDMA_FMT_PM24:  aligned = fifo_out_data;
         emdma_pkg::EMDMA_FMT_DM16:  aligned = {fifo_out_data[15:0], 8'h00};
         emdma_pkg::EMDMA_FMT_DM8HI: aligned = {fifo_out_data[15:8], 16'h0000};
         emdma_pkg::EMDMA_FMT_DM8LO: aligned = {fifo_out_data[7:0], 16'h0000};
      endcase
      unique case (fmt_reg)
         emdma_pkg::EMDMA_FMT_PM24:  load_word = {asm_reg[15:0], rd_byte};
         emdma_pkg::EMDMA_FMT_DM16:  load_word = {8'h00, asm_reg[7:0], rd_byte};
         emdma_pkg::EMDMA_FMT_DM8HI: load_word = {8'h00, rd_byte, 8'h00};
         emdma_pkg::EMDMA_FMT_DM8LO: load_word = {16'h0000, rd_byte};
      endcase
   end
   assign byte_out = (idx_reg == 2'h0) ? aligned[23:16] : sh_reg[23:16];

   // load must find room before a word begins; store needs a word in hand
   assign dma_byte_req = dma_busy && (word_count != 14'h0000) &&
                         (dir_reg ? ((idx_reg != 2'h0) || fifo_out_valid)
                                  : ((idx_reg != 2'h0) || fifo_in_ready));
   assign store_pop = start_dma && dir_reg && (idx_reg == 2'h0);

   // on-chip side of the engine
   assign load_pop = !dir_reg && dma_busy && fifo_out_valid && (!mem_req || mem_grant);
   assign st_issue = dir_reg && dma_busy && (mem_left_reg != 14'h0000) && !rd_pend_reg &&
                     !mem_req && fifo_in_ready;
   assign fifo_in_valid  = dir_reg ? rd_pend_reg : (byte_done && last_byte);
   assign fifo_in_data   = dir_reg ? mem_rdata : load_word;
   assign fifo_out_ready = dir_reg ? store_pop : load_pop;

   assign dma_start  = word_count_write && !dma_busy && (word_count_wdata != 14'h0000);
   assign dma_finish = dma_busy && (word_count == 14'h0000) &&
                       (dir_reg || (!fifo_out_valid && !mem_req));

   emdma_fifo #(
      .WIDTH (`EMDMA_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // combined select enables
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         combined_select_enables <= `EMDMA_CMS_EN_RESET;
      end else if (cms_en_write) begin
         combined_select_enables <= cms_en_wdata;
      end
   end

   // core request capture and internal data path
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cpend_reg   <= 1'b0;
         cio_reg     <= 1'b0;
         cwe_reg     <= 1'b0;
         caddr_reg   <= 14'h0000;
         cwdata_reg  <= 16'h0000;
         core_ack    <= 1'b0;
         core_rdata  <= 16'h0000;
         dm_int_sel  <= 1'b0;
         dm_int_addr <= 14'h0000;
      end else begin
         if (core_req && !core_is_int) begin
            cpend_reg  <= 1'b1;
            cio_reg    <= core_io;
            cwe_reg    <= core_we;
            caddr_reg  <= core_addr;
            cwdata_reg <= core_wdata;
         end else if (start_core) begin
            cpend_reg <= 1'b0;
         end
         dm_int_sel <= core_is_int;
         if (core_is_int) begin
            dm_int_addr <= core_addr;
         end
         core_ack <= core_is_int ||
                     ((xs_reg == emdma_pkg::EMDMA_XS_RELEASE) && !owner_dma_reg);
         if ((xs_reg == emdma_pkg::EMDMA_XS_RELEASE) && !owner_dma_reg) begin
            core_rdata <= cap_reg[15:0];
         end
      end
   end

   // shared external bus sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         xs_reg                 <= emdma_pkg::EMDMA_XS_IDLE;
         wait_reg               <= 3'h0;
         owner_dma_reg          <= 1'b0;
         ext_addr               <= 14'h0000;
         ext_data_out           <= 24'h000000;
         ext_data_oe_n          <= 3'h7;
         ext_rd_n               <= 1'b1;
         ext_wr_n               <= 1'b1;
         program_space_select_n <= 1'b1;
         data_space_select_n    <= 1'b1;
         io_space_select_n      <= 1'b1;
         boot_select_n          <= 1'b1;
         combined_select_n      <= 1'b1;
      end else begin
         unique case (xs_reg)
            emdma_pkg::EMDMA_XS_IDLE: begin
               if (start_core) begin
                  xs_reg              <= emdma_pkg::EMDMA_XS_STROBE;
                  owner_dma_reg       <= 1'b0;
                  wait_reg            <= core_wait;
                  ext_addr            <= core_ext_addr;
                  ext_data_out        <= {8'h00, cwdata_reg};
                  ext_data_oe_n       <= cwe_reg ? 3'h4 : 3'h7;
                  ext_rd_n            <= cwe_reg;
                  ext_wr_n            <= !cwe_reg;
                  data_space_select_n <= cio_reg;
                  io_space_select_n   <= !cio_reg;
                  combined_select_n   <= cio_reg ? !combined_select_enables[`EMDMA_SEL_IO_SPACE_SELECT]
                                                 : !combined_select_enables[`EMDMA_SEL_DMS];
               end else if (start_dma) begin
                  xs_reg            <= emdma_pkg::EMDMA_XS_STROBE;
                  owner_dma_reg     <= 1'b1;
                  wait_reg          <= byte_space_wait_count;
                  ext_addr          <= bptr_reg[13:0];
                  ext_data_out      <= {bptr_reg[21:14], byte_out, 8'h00};
                  ext_data_oe_n     <= dir_reg ? 3'h1 : 3'h3;
                  ext_rd_n          <= dir_reg;
                  ext_wr_n          <= !dir_reg;
                  boot_select_n     <= sys_ctrl[`EMDMA_BMS_DIS_BIT];
                  combined_select_n <= !combined_select_enables[`EMDMA_SEL_BMS];
               end
            end
            emdma_pkg::EMDMA_XS_STROBE: begin
               if (strobe_end) begin
                  xs_reg              <= emdma_pkg::EMDMA_XS_RELEASE;
                  ext_rd_n            <= 1'b1;
                  ext_wr_n            <= 1'b1;
                  data_space_select_n <= 1'b1;
                  io_space_select_n   <= 1'b1;
                  boot_select_n       <= 1'b1;
                  combined_select_n   <= 1'b1;
               end else begin
                  wait_reg <= 3'(wait_reg - 3'h1);
               end
            end
            emdma_pkg::EMDMA_XS_RELEASE: begin
               xs_reg        <= emdma_pkg::EMDMA_XS_IDLE;
               ext_data_oe_n <= 3'h7;
            end
            default: begin
               xs_reg <= emdma_pkg::EMDMA_XS_IDLE;
            end
         endcase
      end
   end

   // read data sampled on the last strobe cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cap_reg <= 24'h000000;
      end else if (strobe_end) begin
         cap_reg <= ext_data_in;
      end
   end

   // engine control, count and byte addressing
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dma_busy     <= 1'b0;
         fmt_reg      <= emdma_pkg::EMDMA_FMT_PM24;
         dir_reg      <= 1'b0;
         hold_reg     <= 1'b0;
         word_count   <= 14'h0000;
         bptr_reg     <= 22'h000000;
         idx_reg      <= 2'h0;
         asm_reg      <= 16'h0000;
         sh_reg       <= 24'h000000;
         dma_done_irq <= 1'b0;
         core_hold    <= 1'b0;
         core_restart <= 1'b0;
      end else begin
         dma_done_irq <= 1'b0;
         core_restart <= 1'b0;
         if (dma_start) begin
            dma_busy   <= 1'b1;
            fmt_reg    <= emdma_pkg::emdma_fmt_t'(transfer_format);
            dir_reg    <= transfer_direction;
            hold_reg   <= hold_off_and_restart;
            core_hold  <= hold_off_and_restart;
            word_count <= word_count_wdata;
            bptr_reg   <= {byte_start_page, byte_start_address};
            idx_reg    <= 2'h0;
         end else if (word_count_write && !dma_busy) begin
            word_count <= word_count_wdata;
         end else if (dma_finish) begin
            dma_busy     <= 1'b0;
            dma_done_irq <= 1'b1;
            core_hold    <= 1'b0;
            core_restart <= hold_reg;
         end
         if (start_dma) begin
            sh_reg <= (idx_reg == 2'h0) ? {aligned[15:0], 8'h00} : {sh_reg[15:0], 8'h00};
         end
         if (byte_done) begin
            bptr_reg <= 22'(bptr_reg + 22'h000001);
            asm_reg  <= {asm_reg[7:0], rd_byte};
            if (last_byte) begin
               idx_reg    <= 2'h0;
               word_count <= 14'(word_count - 14'h0001);
            end else begin
               idx_reg <= 2'(idx_reg + 2'h1);
            end
         end
      end
   end

   // on-chip memory port, always on-chip whatever the overlays say
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mem_req      <= 1'b0;
         mem_we       <= 1'b0;
         mem_pm       <= 1'b0;
         mem_addr     <= 14'h0000;
         mem_wdata    <= 24'h000000;
         mptr_reg     <= 14'h0000;
         mem_left_reg <= 14'h0000;
         rd_pend_reg  <= 1'b0;
      end else begin
         rd_pend_reg <= mem_req && mem_grant && !mem_we;
         if (dma_start) begin
            mptr_reg     <= onchip_start_address;
            mem_left_reg <= word_count_wdata;
            mem_pm       <= (transfer_format == 2'h0);
         end else if (load_pop) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= mptr_reg;
            mem_wdata <= fifo_out_data;
            mptr_reg  <= 14'(mptr_reg + 14'h0001);
         end else if (st_issue) begin
            mem_req      <= 1'b1;
            mem_we       <= 1'b0;
            mem_addr     <= mptr_reg;
            mptr_reg     <= 14'(mptr_reg + 14'h0001);
            mem_left_reg <= 14'(mem_left_reg - 14'h0001);
         end else if (mem_req && mem_grant) begin
            mem_req <= 1'b0;
         end
      end
   end

endmodule

/* File: test/emdma_chk.sv */
// port checker for emdma_top
// assumes one clock domain, bound by the line at the foot
`timescale 1ns/100ps
module emdma_chk (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic [1:0]  data_overlay_select,
   input wire logic [15:0] sys_ctrl,
   input wire logic        core_req,
   input wire logic        core_io,
   input wire logic        core_ack,
   input wire logic        dm_int_sel,
   input wire logic [13:0] ext_addr,
   input wire logic        data_space_select_n,
   input wire logic        io_space_select_n,
   input wire logic        boot_select_n,
   input wire logic        combined_select_n,
   input wire logic [3:0]  combined_select_enables,
   input wire logic [13:0] word_count,
   input wire logic        dma_busy,
   input wire logic        dma_done_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_cms;
      (!data_space_select_n && combined_select_enables[1]) || (!boot_select_n &&
      combined_select_enables[2]) || (!io_space_select_n && combined_select_enables[3])
      |-> !combined_select_n;
   endproperty
   a_cms: assert property (p_cms) else $error("combined select");
   property p_bms; $past(sys_ctrl[3]) |-> boot_select_n; endproperty
   a_bms: assert property (p_bms) else $error("boot select");
   property p_rst; $rose(reset_n) |-> combined_select_enables == 4'hB; endproperty
   a_rst: assert property (p_rst) else $error("enables");
   property p_int; core_req && !core_io && data_overlay_select == 2'h0 |=> core_ack && dm_int_sel;
   endproperty
   a_int: assert property (p_int) else $error("internal");
   property p_a13; !data_space_select_n && data_overlay_select inside {2'h1, 2'h2}
      |-> ext_addr[13] == data_overlay_select[1]; endproperty
   a_a13: assert property (p_a13) else $error("overlay bit");
   property p_io; !io_space_select_n |-> ext_addr[13:11] == 3'h0; endproperty
   a_io: assert property (p_io) else $error("io address");
   property p_cnt; dma_busy && $past(dma_busy) && $changed(word_count)
      |-> word_count == $past(word_count) - 14'h1; endproperty
   a_cnt: assert property (p_cnt) else $error("count step");
   property p_done; dma_done_irq |-> word_count == 14'h0 ##1 !dma_done_irq; endproperty
   a_done: assert property (p_done) else $error("done");
   c_done: cover property (dma_done_irq);
   c_io: cover property (!io_space_select_n && !combined_select_n);
   c_bms: cover property (!boot_select_n);
endmodule
bind emdma_top emdma_chk chk_i (.*);

/* File: test/emdma_ext_model.sv */
// byte-wide external memory model, byte = low address bits xor 0x5A
// assumes active-low strobes, one clock
`timescale 1ns/100ps
module emdma_ext_model (
   input  wire logic        clk_sys,
   input  wire logic        ext_rd_n,
   input  wire logic        ext_wr_n,
   input  wire logic [13:0] ext_addr,
   input  wire logic [23:0] ext_data_out,
   output logic      [23:0] ext_data_in,
   output logic      [7:0]  wr_byte,
   output logic      [7:0]  rd_page
);
   logic [23:0] last = '0;
   // released bus inverts, never holds the old value
   assign ext_data_in = ext_rd_n ? ~last : {8'hA5, ext_addr[7:0] ^ 8'h5A, ext_addr[7:0]};
   always_ff @(posedge clk_sys) begin
      if (!ext_rd_n) last <= ext_data_in;
      if (!ext_wr_n) wr_byte <= ext_data_out[15:8];
      if (!ext_rd_n) rd_page <= ext_data_out[23:16];
   end
endmodule

/* File: test/tb_top.sv */
// bench for emdma_top: access table, byte transfers, reset
// assumes bound checker and external memory model
`timescale 1ns/100ps
module tb_top;
   logic        clk_sys = '0, reset_n = '0, cms_en_write = '0, core_req = '0, core_io = '0;
   logic        core_we = '0, transfer_direction = '0, hold_off_and_restart = '0;
   logic        word_count_write = '0, mem_grant = '0;
   logic [1:0]  data_overlay_select = '0, transfer_format = '0;
   logic [2:0]  data_wait_count = 3'h1, byte_space_wait_count = '0;
   logic [3:0]  cms_en_wdata = 4'hF;
   logic [7:0]  byte_start_page = 8'h01;
   logic [11:0] io_region_wait_counts = 12'hE84;
   logic [13:0] core_addr = '0, onchip_start_address = '0;
   logic [13:0] byte_start_address = 14'h3FFE, word_count_wdata = 14'h3;
   logic [15:0] sys_ctrl = '0, core_wdata = 16'h1234;
   logic [23:0] mem_rdata = 24'h0000C3;
   logic        core_ack, dm_int_sel, ext_rd_n, ext_wr_n, program_space_select_n, mem_pm;
   logic        data_space_select_n, io_space_select_n, boot_select_n, combined_select_n;
   logic        dma_busy, dma_done_irq, core_hold, core_restart, mem_req, mem_we;
   logic [2:0]  ext_data_oe_n;
   logic [3:0]  combined_select_enables;
   logic [7:0]  wr_byte, rd_page;
   logic [13:0] dm_int_addr, ext_addr, word_count, mem_addr;
   logic [15:0] core_rdata;
   logic [23:0] ext_data_in, ext_data_out, mem_wdata;
   int          n_fail = 0, n_compared = 0, cycles = 0, f = 9, widx = 0, n;
   // io, overlay, address, cycles to acknowledge
   logic [20:0] rows [5] = '{{3'h0, 14'h2000, 4'h1}, {3'h1, 14'h0123, 4'h5},
      {3'h2, 14'h1FFF, 4'h5}, {3'h4, 14'h07FF, 4'hB}, {3'h4, 14'h0200, 4'h4}};
   emdma_top DUT (.*);
   emdma_ext_model ext_mem (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [23:0] exp_word(input int w);
      logic [7:0] b [3];
      logic [7:0] p;
      p = 8'hFE + 8'(w * ((f == 0) ? 3 : (f == 1) ? 2 : 1));
      for (int k = 0; k < 3; k++) b[k] = (p + 8'(k)) ^ 8'h5A;
      case (f)
         0: return {b[0], b[1], b[2]};
         1: return {8'h00, b[0], b[1]};
         2: return {8'h00, b[0], 8'h00};
         default: return {16'h0000, b[0]};
      endcase
   endfunction
   initial forever #5 clk_sys = ~clk_sys;
   // toggled grant stalls the on-chip side every other cycle
   always @(posedge clk_sys) #1 mem_grant = ~mem_grant;
   always @(posedge clk_sys) begin
      cycles++;
      if (mem_req && mem_grant && mem_we && f < 4) begin
         chk({mem_pm, mem_wdata}, {f == 0, exp_word(widx)});
         chk(mem_addr, 14'(f * 16 + widx));
         widx++;
      end
      if (cycles == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 5; i++) begin
         {core_io, data_overlay_select, core_addr} = rows[i][20:4];
         core_we = (i == 4);
         core_req = 1'b1;
         @(posedge clk_sys);
         #1 core_req = 1'b0;
         for (n = 1; core_ack !== 1'b1 && n < 20; n++) @(posedge clk_sys) #1;
         chk(n, rows[i][3:0]);
         chk({dm_int_sel, dm_int_addr}, {i == 0, 14'h2000});
         if (i > 0 && i < 4)
            chk(core_rdata, {core_addr[7:0] ^ 8'h5A, core_addr[7:0]});
      end
      for (f = 0; f < 5; f++) begin
         {transfer_direction, transfer_format} = (f == 4) ? 3'h7 : 3'(f);
         hold_off_and_restart = (f == 0);
         byte_space_wait_count = 3'(f);
         sys_ctrl = (f == 3) ? 16'h0008 : 16'h0000;
         onchip_start_address = 14'(f * 16);
         widx = 0;
         word_count_write = 1'b1;
         @(posedge clk_sys);
         #1 word_count_write = 1'b0;
         for (n = 0; dma_done_irq !== 1'b1 && n < 300; n++) begin
            @(posedge clk_sys) #1;
            if (n == 5) chk(core_hold, f == 0);
         end
         chk({core_restart, word_count}, {f == 0, 14'h0});
         if (f < 4) chk({widx[7:0], rd_page}, {8'h3, 8'h02});
         else chk(wr_byte, 8'hC3);
      end
      cms_en_write = 1'b1;
      word_count_write = 1'b1;
      @(posedge clk_sys);
      #1 {cms_en_write, word_count_write} = 2'h0;
      chk(combined_select_enables, 4'hF);
      repeat (6) @(posedge clk_sys);
      #1 reset_n = 1'b0;
      #1 chk({combined_select_enables, dma_busy, word_count, program_space_select_n},
             {4'hB, 16'h0001});
      @(posedge clk_sys) #1 reset_n = 1'b1;
      @(posedge clk_sys) #1 chk({combined_select_enables, dma_busy}, {4'hB, 1'b0});
      stop_test();
   end
endmodule
